// ===== pic_host_pkg.sv
// Constants shared by the interrupt controller host and its pin engine.
package pic_host_pkg;
  // Command register offsets of the host's own register port.
  localparam logic [2:0] REG_CTRL    = 3'h0;
  localparam logic [2:0] REG_INIT1   = 3'h1;
  localparam logic [2:0] REG_INIT2   = 3'h2;
  localparam logic [2:0] REG_INIT3   = 3'h3;
  localparam logic [2:0] REG_INIT4   = 3'h4;
  localparam logic [2:0] REG_MASK    = 3'h5;
  localparam logic [2:0] REG_OPWORD  = 3'h6;
  localparam logic [2:0] REG_STATUS  = 3'h7;
  // Control register bit positions.
  localparam int CTRL_INIT  = 0;
  localparam int CTRL_MASK  = 1;
  localparam int CTRL_OP    = 2;
  localparam int CTRL_READ  = 3;
  localparam int CTRL_ACK   = 4;
  // Bits of the first initialization word.
  localparam int INIT1_FOURTH = 0;
  localparam int INIT1_SINGLE = 1;
  localparam int INIT1_INTVL  = 2;
  localparam int INIT1_LEVEL  = 3;
  localparam int INIT1_MARK   = 4;
  // Bits of the fourth initialization word.
  localparam int INIT4_VECMODE = 0;
  localparam int INIT4_AUTOEOS = 1;
  // Call opcode driven on the first acknowledge of the three-byte mode.
  localparam logic [7:0] CALL_OPCODE = 8'hCD;
  // Non-specific end of service operation word.
  localparam logic [7:0] EOS_NONSPEC = 8'h20;
  // Read selection words for the request and in-service registers.
  localparam logic [7:0] READ_SEL_REQ = 8'h0A;
  localparam logic [7:0] READ_SEL_INS = 8'h0B;
  // Bus phase timing, in ns, and derived cycle counts at 40 MHz.
  localparam int CLK_PERIOD_NS = 25;
  localparam int STROBE_NS     = 100;
  localparam int SETUP_NS      = 50;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC  = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SEQ_WIDTH = 8;
endpackage : pic_host_pkg

// ===== pic_pin_cycle.sv
// One timed bus cycle on the controller pins: setup, strobe low, release.
`timescale 1ns/100ps
module pic_pin_cycle
  import pic_host_pkg::*;
#(
  parameter int SETUP = SETUP_CYC,
  parameter int PULSE = STROBE_CYC
) (
  // Clock and reset.
  input  wire logic       mclk,
  input  wire logic       nrst,
  // Cycle request.
  input  wire logic       start,
  output logic            busy,
  output logic            strobeOn,
  output logic            sampleNow,
  output logic            doneNow
);
  if (SETUP < 1 || PULSE < 1 || SETUP > 255 || PULSE > 255) begin : g_bad
    $error("pic_pin_cycle: timing out of range");
  end

  typedef enum {IDLE, SETUPPH, PULSEPH, HOLDPH} phase_e;
  phase_e     phase_r;
  phase_e     phase_nxt;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;

  always_comb begin
    phase_nxt = phase_r;
    cnt_nxt   = cnt_r;
    case (phase_r)
      IDLE: begin
        if (start) begin
          phase_nxt = SETUPPH;
          cnt_nxt   = 8'(SETUP - 1);
        end
      end
      SETUPPH: begin
        if (cnt_r == 8'h00) begin
          phase_nxt = PULSEPH;
          cnt_nxt   = 8'(PULSE - 1);
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      PULSEPH: begin
        if (cnt_r == 8'h00) begin
          phase_nxt = HOLDPH;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      // A start during hold chains the next cycle with select kept low.
      HOLDPH: begin
        if (start) begin
          phase_nxt = SETUPPH;
          cnt_nxt   = 8'(SETUP - 1);
        end else begin
          phase_nxt = IDLE;
        end
      end
      default: phase_nxt = IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      phase_r <= IDLE;
      cnt_r   <= 8'h00;
    end else begin
      phase_r <= phase_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  assign busy      = (phase_r != IDLE);
  assign strobeOn  = (phase_r == PULSEPH);
  assign sampleNow = (phase_r == PULSEPH) && (cnt_r == 8'h00);
  assign doneNow   = (phase_r == HOLDPH);
endmodule : pic_pin_cycle

// ===== pic_host.sv
// Host that programs the interrupt controller and runs acknowledge cycles.
// Operation
// - Host asserts chip select for every register write and read, not for acknowledges.
// - In call mode, host issues two more acknowledges, low, high.
// - Vector mode uses exactly two acknowledges.
// - Host sends two to four init bytes first.
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/100ps
module pic_host
  import pic_host_pkg::*;
(
  // Clock and reset.
  input  wire logic       mclk,
  input  wire logic       nrst,
  // Software register port.
  input  wire logic [2:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdata,
  // Controller pins.
  output logic            chipSelect_n,
  output logic            readStrobe_n,
  output logic            writeStrobe_n,
  output logic            acknowledge_strobe_n,
  output logic            register_select_line,
  input  wire logic       intReq,
  input  wire logic [7:0] dataIn,
  output logic      [7:0] dataOut,
  output logic            dataOe
);
  typedef enum {IDLE, WR_INIT1, WR_INIT2, WR_INIT3, WR_INIT4, WR_MASK,
                WR_OP, WR_RDSEL, RD_STAT, ACK_ONE, ACK_TWO, ACK_THREE,
                WR_EOS} host_e;

  host_e      state_r;
  host_e      state_nxt;
  logic [7:0] init1_r, init2_r, init3_r, init4_r, mask_r, opWord_r;
  logic [7:0] init1_nxt, init2_nxt, init3_nxt, init4_nxt, mask_nxt;
  logic [7:0] opWord_nxt;
  logic [7:0] status_r, status_nxt;
  logic [7:0] ack1_r, ack2_r, ack3_r;
  logic [7:0] ack1_nxt, ack2_nxt, ack3_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic       busy_r, busy_nxt;
  logic       cycStart, cycBusy, cycStrobe, cycSample, cycDone;
  logic       vecMode;

  // Vector mode needs the fourth word flagged in the first word and its mode bit set.
  assign vecMode = init1_r[INIT1_FOURTH] && init4_r[INIT4_VECMODE];

  pic_pin_cycle #(.SETUP(SETUP_CYC), .PULSE(STROBE_CYC)) u_cycle (
    .mclk      (mclk),
    .nrst      (nrst),
    .start     (cycStart),
    .busy      (cycBusy),
    .strobeOn  (cycStrobe),
    .sampleNow (cycSample),
    .doneNow   (cycDone)
  );

  function automatic host_e after_init(input host_e cur, input logic [7:0] w1);
    host_e r;
    r = IDLE;
    case (cur)
      WR_INIT1: r = WR_INIT2;
      WR_INIT2: r = !w1[INIT1_SINGLE] ? WR_INIT3 :
                    (w1[INIT1_FOURTH] ? WR_INIT4 : IDLE);
      WR_INIT3: r = w1[INIT1_FOURTH] ? WR_INIT4 : IDLE;
      default:  r = IDLE;
    endcase
    return r;
  endfunction : after_init

  always_comb begin
    state_nxt = state_r;
    init1_nxt = init1_r;
    init2_nxt = init2_r;
    init3_nxt = init3_r;
    init4_nxt = init4_r;
    mask_nxt  = mask_r;
    opWord_nxt = opWord_r;
    status_nxt = status_r;
    ack1_nxt  = ack1_r;
    ack2_nxt  = ack2_r;
    ack3_nxt  = ack3_r;
    busy_nxt  = (state_r != IDLE);
    cycStart  = 1'b0;
    rdata_nxt = 8'h00;
    if (regWr && state_r == IDLE) begin
      case (regAddr)
        REG_INIT1: init1_nxt = regWdata | (8'h01 << INIT1_MARK);
        REG_INIT2: init2_nxt = regWdata;
        REG_INIT3: init3_nxt = regWdata;
        REG_INIT4: init4_nxt = regWdata;
        REG_MASK:  mask_nxt  = regWdata;
        REG_OPWORD: opWord_nxt = regWdata;
        REG_CTRL: begin
          if (regWdata[CTRL_INIT]) state_nxt = WR_INIT1;
          else if (regWdata[CTRL_MASK]) state_nxt = WR_MASK;
          else if (regWdata[CTRL_OP]) state_nxt = WR_OP;
          else if (regWdata[CTRL_READ]) state_nxt = WR_RDSEL;
          else if (regWdata[CTRL_ACK]) state_nxt = ACK_ONE;
        end
        default: ;
      endcase
      if (regAddr == REG_CTRL && regWdata[4:0] != 5'h00) begin
        cycStart = 1'b1;
      end
    end
    if (regRd) begin
      case (regAddr)
        REG_INIT1:  rdata_nxt = init1_r;
        REG_INIT2:  rdata_nxt = init2_r;
        REG_INIT3:  rdata_nxt = init3_r;
        REG_INIT4:  rdata_nxt = init4_r;
        REG_MASK:   rdata_nxt = mask_r;
        REG_OPWORD: rdata_nxt = status_r;
        REG_STATUS: rdata_nxt = {ack1_r[7:6], 3'h0, intReq, vecMode,
                                 busy_r};
        default:    rdata_nxt = {ack3_r[7:4], ack2_r[3:0]};
      endcase
    end
    if (cycSample) begin
      case (state_r)
        RD_STAT:   status_nxt = dataIn;
        ACK_ONE:   ack1_nxt = vecMode ? 8'h00 : dataIn;
        ACK_TWO:   ack2_nxt = dataIn;
        ACK_THREE: ack3_nxt = dataIn;
        default: ;
      endcase
    end
    if (cycDone) begin
      cycStart = 1'b1;
      case (state_r)
        WR_INIT1, WR_INIT2, WR_INIT3: begin
          state_nxt = after_init(state_r, init1_r);
          cycStart  = (state_nxt != IDLE);
        end
        WR_RDSEL: state_nxt = RD_STAT;
        ACK_ONE:  state_nxt = ACK_TWO;
        // Vector mode stops after the second pulse.
        ACK_TWO: begin
          state_nxt = vecMode ? IDLE : ACK_THREE;
          cycStart  = !vecMode;
        end
        default: begin
          state_nxt = IDLE;
          cycStart  = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_r  <= IDLE;
      init1_r  <= 8'h10;
      init2_r  <= 8'h00;
      init3_r  <= 8'h00;
      init4_r  <= 8'h00;
      mask_r   <= 8'h00;
      opWord_r <= EOS_NONSPEC;
      status_r <= 8'h00;
      ack1_r   <= 8'h00;
      ack2_r   <= 8'h00;
      ack3_r   <= 8'h00;
      rdata_r  <= 8'h00;
      busy_r   <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      init1_r  <= init1_nxt;
      init2_r  <= init2_nxt;
      init3_r  <= init3_nxt;
      init4_r  <= init4_nxt;
      mask_r   <= mask_nxt;
      opWord_r <= opWord_nxt;
      status_r <= status_nxt;
      ack1_r   <= ack1_nxt;
      ack2_r   <= ack2_nxt;
      ack3_r   <= ack3_nxt;
      rdata_r  <= rdata_nxt;
      busy_r   <= busy_nxt;
    end
  end

  assign regRdata = rdata_r;

  // Pin drive: select is held over the whole cycle of a register access.
  logic isWrite, isRead, isAck;
  assign isWrite = state_r inside {WR_INIT1, WR_INIT2, WR_INIT3, WR_INIT4,
                                   WR_MASK, WR_OP, WR_RDSEL, WR_EOS};
  assign isRead  = (state_r == RD_STAT);
  assign isAck   = state_r inside {ACK_ONE, ACK_TWO, ACK_THREE};
  assign chipSelect_n  = !(cycBusy && (isWrite || isRead));
  assign writeStrobe_n = !(cycStrobe && isWrite);
  assign readStrobe_n  = !(cycStrobe && isRead);
  assign acknowledge_strobe_n = !(cycStrobe && isAck);
  assign register_select_line = state_r inside {WR_INIT2, WR_INIT3,
                                                 WR_INIT4, WR_MASK};
  assign dataOe = cycBusy && isWrite;

  always_comb begin
    case (state_r)
      WR_INIT1: dataOut = init1_r;
      WR_INIT2: dataOut = init2_r;
      WR_INIT3: dataOut = init3_r;
      WR_INIT4: dataOut = init4_r;
      WR_MASK:  dataOut = mask_r;
      WR_OP:    dataOut = opWord_r;
      WR_RDSEL: dataOut = READ_SEL_REQ;
      default:  dataOut = 8'h00;
    endcase
  end

  // Steps of an acknowledge sequence as the pin engine finishes them.
  sequence firstAckEnd_s;
    state_r == ACK_ONE && cycDone;
  endsequence
  sequence vecLastEnd_s;
    state_r == ACK_TWO && cycDone && vecMode;
  endsequence

  ackCount_a: assert property (@(posedge mclk) disable iff (!nrst)
    vecLastEnd_s |=> state_r == IDLE)
    else $error("vector mode ran a third acknowledge");
  ackChain_a: assert property (@(posedge mclk) disable iff (!nrst)
    firstAckEnd_s |=> (state_r == ACK_TWO && cycBusy))
    else $error("second acknowledge cycle did not start");
  selHeld_a: assert property (@(posedge mclk) disable iff (!nrst)
    !writeStrobe_n |-> !chipSelect_n)
    else $error("write strobe without chip select");
  initFirst_a: assert property (@(posedge mclk) disable iff (!nrst)
    (state_r == WR_INIT1 && dataOe) |->
      (dataOut[INIT1_MARK] && !register_select_line))
    else $error("first init word malformed");
endmodule : pic_host

// ===== pic_device_model.sv
// Behavioural model of the interrupt controller device on the host pins.
`timescale 1ns/100ps
module pic_device_model (
  // Clock used only to sample the pins.
  input  wire logic       mclk,
  // Host pins.
  input  wire logic       chipSelect_n,
  input  wire logic       readStrobe_n,
  input  wire logic       writeStrobe_n,
  input  wire logic       acknowledge_strobe_n,
  input  wire logic       register_select_line,
  input  wire logic [7:0] dataOut,
  output logic            intReq,
  output logic      [7:0] dataIn,
  // Request lines.
  input  wire logic [7:0] reqLines
);
  logic [7:0] pend = 8'h00, inSvc = 8'h00, lineMask = 8'h00, page = 8'h00;
  logic [7:0] reqOld = 8'h00, lastBus = 8'h00, drv;
  logic [2:0] lowAddr = 3'h0, lvl = 3'h7, casCode = 3'h7;
  logic [1:0] wordIdx = 2'h0, ackNum = 2'h0;
  logic [3:0] pick;
  logic       single = 1'b1, fourth = 1'b0, intvl4 = 1'b0, lvlMode = 1'b0;
  logic       vecMode = 1'b0, autoEos = 1'b0, readIns = 1'b0, on;
  logic       wrOld = 1'b1, ackOld = 1'b1;
  function automatic logic [3:0] first(input logic [7:0] x);
    for (int i = 0; i < 8; i++) if (x[i]) return 4'(i);
    return 4'h8;
  endfunction : first
  assign intReq = first(pend & ~lineMask) < first(inSvc);
  always @(posedge mclk) begin
    pend = pend | (reqLines & (lvlMode ? 8'hFF : ~reqOld));
    reqOld = reqLines;
    if (wrOld && !writeStrobe_n && !chipSelect_n) begin
      if (!register_select_line && dataOut[4]) begin
        {lineMask, readIns, wordIdx, pend, reqOld} = {11'h001, 16'h00FF};
        {lowAddr, lvlMode, intvl4, single, fourth} = {dataOut[7:5], dataOut[3:0]};
        if (!fourth) {vecMode, autoEos} = 2'b00;
      end else if (register_select_line && wordIdx == 2'h1) begin
        page = dataOut;
        wordIdx = !single ? 2'h2 : (fourth ? 2'h3 : 2'h0);
      end else if (register_select_line && wordIdx == 2'h2)
        wordIdx = fourth ? 2'h3 : 2'h0;
      else if (register_select_line && wordIdx == 2'h3) begin
        {autoEos, vecMode} = dataOut[1:0];
        wordIdx = 2'h0;
      end else if (register_select_line)
        lineMask = dataOut;
      else if (dataOut[3])
        readIns = dataOut[1:0] == 2'b11;
      else if (dataOut[7:5] == 3'b001)
        inSvc = inSvc & (inSvc - 8'h01);
    end
    if (ackOld && !acknowledge_strobe_n) begin
      ackNum = ackNum + 2'h1;
      if (ackNum == 2'h1) begin
        pick = first(pend & ~lineMask);
        lvl = pick[3] ? 3'h7 : pick[2:0];
        if (!pick[3]) begin
          inSvc[lvl] = 1'b1;
          pend[lvl] = 1'b0;
        end
      end
    end
    if (!ackOld && acknowledge_strobe_n && ackNum == 2'h1)
      casCode = lvl;
    if (!ackOld && acknowledge_strobe_n &&
        ackNum == (vecMode ? 2'h2 : 2'h3)) begin
      if (autoEos) inSvc[lvl] = 1'b0;
      ackNum = 2'h0;
    end
    if (on) lastBus = drv;
    wrOld = writeStrobe_n;
    ackOld = acknowledge_strobe_n;
  end
  // A released bus shows the inverse of its last value, never a held copy.
  always_comb begin
    on = 1'b1;
    drv = readIns ? inSvc : pend;
    if (!acknowledge_strobe_n) begin
      case ({vecMode, ackNum})
        3'b001: drv = 8'hCD;
        3'b010: drv = intvl4 ? {lowAddr, lvl, 2'b00}
                             : {lowAddr[2:1], lvl, 3'b000};
        3'b011: drv = page;
        3'b110: drv = {page[7:3], lvl};
        default: on = 1'b0;
      endcase
    end else on = !readStrobe_n && !chipSelect_n;
    dataIn = on ? drv : ~lastBus;
  end
endmodule : pic_device_model

// ===== tb_pic_host.sv
// Self-checking testbench for the interrupt controller host.
`timescale 1ns/100ps
module tb_pic_host
  import pic_host_pkg::*;
;
  logic       mclk = 1'b0, nrst = 1'b0, regWr = 1'b0, regRd = 1'b0;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWdata = 8'h00, reqLines = 8'h00, regRdata, dataIn, dataOut, v;
  logic       chipSelect_n, readStrobe_n, writeStrobe_n, dataOe, intReq;
  logic       acknowledge_strobe_n, register_select_line;
  int         errors = 0, comparisons = 0;
  initial forever #12.5 mclk = ~mclk;
  pic_host dut_u (.mclk, .nrst, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata, .chipSelect_n, .readStrobe_n, .writeStrobe_n,
    .acknowledge_strobe_n, .register_select_line, .intReq, .dataIn,
    .dataOut, .dataOe);
  pic_device_model dev_u (.mclk, .chipSelect_n, .readStrobe_n,
    .writeStrobe_n, .acknowledge_strobe_n, .register_select_line,
    .dataOut, .intReq, .dataIn, .reqLines);
  task automatic wrap_up;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  task automatic check(input string what, input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
    @(posedge mclk);
  endtask : wr
  task automatic rd(input logic [2:0] a);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    @(negedge mclk);
    v = regRdata;
    @(posedge mclk);
  endtask : rd
  // Starts one host command and waits, bounded, until busy drops.
  task automatic run(input int bitNo);
    wr(REG_CTRL, 8'(1 << bitNo));
    for (int i = 0; i < 100; i++) begin
      rd(REG_STATUS);
      if (!v[0]) return;
    end
    errors++;
    wrap_up();
  endtask : run
  task automatic irq(input logic e);
    repeat (3) @(posedge mclk);
    rd(REG_STATUS);
    check("interrupt", {7'h00, v[2]}, {7'h00, e});
  endtask : irq
  task automatic pendChk(input logic [7:0] e);
    run(CTRL_READ);
    rd(REG_OPWORD);
    check("pending", v, e);
  endtask : pendChk
  task automatic ack(input logic [7:0] op, addr, msk);
    run(CTRL_ACK);
    rd(REG_STATUS);
    check("first byte", v & 8'hC0, op);
    rd(REG_CTRL);
    check("address", v & msk, addr);
  endtask : ack
  initial begin
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    rd(REG_STATUS);
    check("reset status", v, 8'h00);
    wr(REG_INIT1, 8'hB6);
    wr(REG_INIT2, 8'h5A);
    run(CTRL_INIT);
    wr(REG_MASK, 8'h00);
    run(CTRL_MASK);
    reqLines <= 8'h24;
    irq(1'b1);
    pendChk(8'h24);
    ack(8'hC0, 8'h58, 8'hFF);
    irq(1'b0);
    pendChk(8'h20);
    wr(REG_OPWORD, EOS_NONSPEC);
    run(CTRL_OP);
    irq(1'b1);
    wr(REG_MASK, 8'h02);
    run(CTRL_MASK);
    reqLines <= 8'h22;
    pendChk(8'h22);
    ack(8'hC0, 8'h54, 8'hFF);
    ack(8'hC0, 8'h5C, 8'hFF);
    run(CTRL_OP);
    wr(REG_INIT1, 8'h1B);
    wr(REG_INIT2, 8'h48);
    wr(REG_INIT4, 8'h03);
    run(CTRL_INIT);
    irq(1'b1);
    check("vector mode", v & 8'h02, 8'h02);
    ack(8'h00, 8'h09, 8'h0F);
    check("cascade", {5'h00, dev_u.casCode}, 8'h01);
    irq(1'b1);
    wr(REG_INIT1, 8'hD2);
    run(CTRL_INIT);
    irq(1'b0);
    check("call mode", v & 8'h02, 8'h00);
    reqLines <= 8'h00;
    repeat (2) @(posedge mclk);
    reqLines <= 8'h08;
    irq(1'b1);
    ack(8'hC0, 8'h48, 8'hFF);
    wrap_up();
  end
endmodule : tb_pic_host
